// >>> rtl/rsf_pkg.sv
package rsf_pkg;

    // Register map, one byte per address.
    localparam logic [7:0] TEMP_UPPER_ADDR   = 8'h0f;
    localparam logic [7:0] STATUS_ADDR       = 8'h0d;

    // Status register field positions.
    localparam int         BACKUP_FLAG_BIT   = 0;
    localparam int         EVENT_FLAG_BIT    = 1;

    // Temperature bits that the upper register returns.
    localparam int         TEMP_UPPER_MSB    = 11;
    localparam int         TEMP_UPPER_LSB    = 4;

    // Values after reset.
    localparam logic       FLAG_RESET        = 1'b0;
    localparam logic       SUPPLY_RESET      = 1'b0;
    localparam logic [7:0] READ_IDLE         = 8'h00;

    // Backup switch mode encodings.
    typedef enum logic [1:0]
    {
        MODE_OFF_LO = 2'b00,
        MODE_DIRECT = 2'b01,
        MODE_LEVEL  = 2'b10,
        MODE_OFF_HI = 2'b11
    } rsf_mode_type;

endpackage

// >>> rtl/rsf_status_temp.sv
// Operation
// - Power-on reset forces the backup switch flag to 0.
// - Mode 00 or 11 holds the backup switch flag at 0.
// - Main-to-backup supply switchover sets a clear backup switch flag.
// - Backup switch flag stays 1 until software writes 0 on main supply or mode 00 or 11 is selected.
// - Temperature upper register returns TEMP[11:4], two's complement.
// - Temperature upper register is read-only; writes change nothing.
`timescale 1ns/1ps

module rsf_status_temp
    import rsf_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic [1:0]  backup_switch_mode_i,
    input  wire logic        on_backup_i,
    input  wire logic        clk_out_event_i,
    input  wire logic [11:0] temp_value_i,
    output logic             backup_switch_flag_o,
    output logic             clock_output_event_flag_o
);

    // Flag state and the values that it takes at the next edge.
    logic       backup_flag_q;
    logic       backup_flag_d;
    logic       event_flag_q;
    logic       event_flag_d;

    // Supply indication one cycle ago, kept for edge detection.
    logic       on_backup_q;
    logic       on_backup_d;

    // Read data register and its next value.
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // Decoded strobes and conditions.
    logic       status_wr;
    logic       status_rd;
    logic       temp_rd;
    logic       temp_wr;
    logic       mode_off;
    logic       switchover;
    logic       backup_clear;
    logic       event_clear;

    // Read views of the two registers.
    logic [7:0] status_word;
    logic [7:0] temp_upper;

    // Address decode, shared by the write path, read path and checks.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // Strobe decode; a write to any other address does nothing here, a read to one returns READ_IDLE.
    assign status_wr  = reg_wr_i && hit(reg_addr_i, STATUS_ADDR);
    assign status_rd  = reg_rd_i && hit(reg_addr_i, STATUS_ADDR);
    assign temp_rd    = reg_rd_i && hit(reg_addr_i, TEMP_UPPER_ADDR);
    assign temp_wr    = reg_wr_i && hit(reg_addr_i, TEMP_UPPER_ADDR);

    // Both disabled encodings of the mode field turn the flag off.
    assign mode_off   = (backup_switch_mode_i == MODE_OFF_LO) ||
                        (backup_switch_mode_i == MODE_OFF_HI);

    // Rising edge of the backup supply indication marks a switchover.
    // The history register resets to main supply, so a module that
    // already runs on backup when reset ends still reports it once.
    assign switchover = on_backup_i && !on_backup_q;

    // Software clears a flag by writing 0 to its bit; a 1 does nothing.
    // The backup flag may only be cleared while running on main supply,
    // so that software cannot lose a switchover it has not yet seen.
    assign backup_clear = status_wr && !reg_wdata_i[BACKUP_FLAG_BIT] &&
                          !on_backup_i;
    assign event_clear  = status_wr && !reg_wdata_i[EVENT_FLAG_BIT];

    // Next flag values; an event in the clearing cycle wins over the
    // clear, and the disabled mode wins over everything for the backup flag.
    always_comb
    begin
        on_backup_d   = on_backup_i;
        backup_flag_d = backup_flag_q;
        event_flag_d  = event_flag_q;
        if (backup_clear)
        begin
            backup_flag_d = 1'b0;
        end
        if (switchover)
        begin
            backup_flag_d = 1'b1;
        end
        if (mode_off)
        begin
            backup_flag_d = 1'b0;
        end
        if (event_clear)
        begin
            event_flag_d = 1'b0;
        end
        if (clk_out_event_i)
        begin
            event_flag_d = 1'b1;
        end
    end

    // Status byte as software sees it; unused bits read as zero.
    always_comb
    begin
        status_word                  = READ_IDLE;
        status_word[BACKUP_FLAG_BIT] = backup_flag_q;
        status_word[EVENT_FLAG_BIT]  = event_flag_q;
    end

    // Integer part of the temperature, already in two's complement.
    assign temp_upper = temp_value_i[TEMP_UPPER_MSB:TEMP_UPPER_LSB];

    // Read data; the temperature register has no write path at all, so
    // a write to it can only fall through to the unchanged state.
    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd_i)
        begin
            if (temp_rd)
            begin
                rdata_d = temp_upper;
            end
            else if (status_rd)
            begin
                rdata_d = status_word;
            end
            else
            begin
                rdata_d = READ_IDLE;
            end
        end
    end

    // Registers; reset stands in for power-on reset.
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            backup_flag_q <= FLAG_RESET;
            event_flag_q  <= FLAG_RESET;
            on_backup_q   <= SUPPLY_RESET;
            rdata_q       <= READ_IDLE;
        end
        else
        begin
            backup_flag_q <= backup_flag_d;
            event_flag_q  <= event_flag_d;
            on_backup_q   <= on_backup_d;
            rdata_q       <= rdata_d;
        end
    end

    // Outputs come straight from the flip-flops.
    assign reg_rdata_o               = rdata_q;
    assign backup_switch_flag_o      = backup_flag_q;
    assign clock_output_event_flag_o = event_flag_q;

    // Reset leaves the backup flag clear.
    a_backup_after_reset: assert property (@(posedge ref_clk_i)
        $past(rst_i) |-> !backup_flag_q)
        else $error("flag not cleared by reset");

    // A disabled mode keeps the flag clear one edge later.
    a_backup_mode_off: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        $past(mode_off) && !$past(rst_i) |-> !backup_flag_q)
        else $error("flag set while mode off");

    // A switchover in an enabled mode sets the flag.
    a_backup_set_switch: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        switchover && !mode_off |=> backup_flag_q)
        else $error("switchover missed");

    // Without a status write the set flag stays set.
    a_backup_flag_holds: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        backup_flag_q && !mode_off && !status_wr |=> backup_flag_q)
        else $error("flag dropped without write");

    // A clearing write while on backup supply is ignored.
    a_backup_clear_blocked: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        backup_flag_q && !mode_off && status_wr && on_backup_i
        |=> backup_flag_q)
        else $error("flag cleared on backup supply");

    // A clearing write on main supply clears the flag.
    a_backup_clear_main: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        backup_clear && !switchover |=> !backup_flag_q)
        else $error("flag not cleared by write");

    // A temperature read returns the integer part one edge later.
    a_temp_read: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        temp_rd |=> reg_rdata_o == $past(temp_value_i[11:4]))
        else $error("bad temperature read");

    // A temperature write touches no state; other events are excluded.
    a_temp_write: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        temp_wr && !reg_rd_i && !switchover && !clk_out_event_i &&
        !mode_off
        |=> $stable(reg_rdata_o) && $stable(backup_flag_q) &&
        $stable(event_flag_q))
        else $error("write changed state");

    // A clock output event sets its flag.
    a_event_flag_set: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        clk_out_event_i |=> event_flag_q)
        else $error("event flag missed");

    // Without a status write the event flag stays set.
    a_event_flag_hold: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        event_flag_q && !status_wr |=> event_flag_q)
        else $error("event flag dropped");

    // A clearing write without an event clears the event flag.
    a_event_flag_clear: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        event_clear && !clk_out_event_i |=> !event_flag_q)
        else $error("event flag not cleared");

    // Main scenarios worth seeing in a run.
    c_switchover: cover property (@(posedge ref_clk_i)
        switchover && !mode_off);
    c_backup_clear: cover property (@(posedge ref_clk_i)
        backup_flag_q ##1 !backup_flag_q);
    c_event_set: cover property (@(posedge ref_clk_i)
        !event_flag_q ##1 event_flag_q);
    c_temp_rd: cover property (@(posedge ref_clk_i)
        temp_rd);
    c_clear_blocked: cover property (@(posedge ref_clk_i)
        backup_flag_q && status_wr && on_backup_i);

endmodule

// >>> testbench/rsf_status_temp_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
miscompares++; $display("wrong value %0t %h %h", $time, g, e); end end
module rsf_status_temp_tb_top;
    import rsf_pkg::*;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, bk = 0, ev = 0;
    logic [7:0]  ad = 8'h00, wd = 8'h00, rdo;
    logic [1:0]  md = 2'h1;
    logic [11:0] tv = 12'h000;
    logic        bkf, ckf;
    logic [15:0] lf = 16'hfe5e;
    int          miscompares = 0, total_checks = 0;
    // Clock at 40 MHz.
    always #12.5 clk = ~clk;
    rsf_status_temp dut (.ref_clk_i(clk), .rst_i(rst), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_addr_i(ad), .reg_wdata_i(wd), .reg_rdata_o(rdo),
        .backup_switch_mode_i(md), .on_backup_i(bk), .clk_out_event_i(ev),
        .temp_value_i(tv), .backup_switch_flag_o(bkf),
        .clock_output_event_flag_o(ckf));
    // Galois-free shift register keeps the stimulus repeatable.
    function logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function logic [7:0] tup(input logic [11:0] t);
        return t[11:4];
    endfunction
    task wrt(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); wr <= 1; ad <= a; wd <= d;
        @(posedge clk); wr <= 0; #1;
    endtask
    task rdc(input logic [7:0] a);
        @(posedge clk); rd <= 1; ad <= a;
        @(posedge clk); rd <= 0; #1;
    endtask
    task close_out;
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence; supply is held on main during reset on purpose.
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 0; #1;
        `CHK({bkf, ckf}, 2'b00)
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk); md <= m ? MODE_LEVEL : MODE_DIRECT; bk <= 1;
            @(posedge clk); #1;
            `CHK(bkf, 1'b1)
            wrt(STATUS_ADDR, 8'h00);
            `CHK(bkf, 1'b1)
            @(posedge clk); md <= m ? MODE_OFF_HI : MODE_OFF_LO;
            @(posedge clk); #1;
            `CHK(bkf, 1'b0)
            @(posedge clk); bk <= 0; md <= MODE_DIRECT;
        end
        @(posedge clk); bk <= 1;
        @(posedge clk); bk <= 0; ev <= 1;
        @(posedge clk); ev <= 0;
        repeat (3) @(posedge clk); #1;
        `CHK(ckf, 1'b1)
        rdc(STATUS_ADDR);
        `CHK(rdo, 8'h03)
        wrt(STATUS_ADDR, 8'h00);
        `CHK({bkf, ckf}, 2'b00)
        rdc(8'h20);
        `CHK(rdo, READ_IDLE)
        // Random temperatures, each preceded by a write that must be ignored.
        repeat (24)
        begin
            @(posedge clk); tv <= lf[11:0]; lf = nxt(lf);
            wrt(TEMP_UPPER_ADDR, lf[7:0]);
            `CHK({bkf, ckf}, 2'b00)
            rdc(TEMP_UPPER_ADDR);
            `CHK(rdo, tup(tv))
            lf = nxt(lf);
        end
        @(posedge clk); tv <= 12'h800;
        rdc(TEMP_UPPER_ADDR);
        `CHK(rdo, 8'h80)
        close_out;
    end
    // A run should take about 160 cycles; 4000 means a hang.
    initial
    begin
        #100000;
        miscompares++;
        close_out;
    end
endmodule
